// *** dsp_pin_load.sv ***
// dsp_pin_load: port pin driver with external pull-up load.
// assumes the direction bit and port value come from the testbench.
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_load (
   input wire logic               dir_out,
   input wire logic               port_val,
   input wire dsp_pkg::dsp_pins_t pins,
   output var logic               pad_a,
   output var logic               pad_b
);
   // driver off: only the pull-up decides the level
   always_comb begin
      pad_a = dir_out ? (pins.override_a ? pins.wave_out_a : port_val) : 1'b1;
      pad_b = dir_out ? (pins.override_b ? pins.wave_out_b : port_val) : 1'b1;
   end
endmodule
`default_nettype wire

// *** dsp_pkg.sv ***
// dsp_pkg: constants, register map and carrier types for the eight-bit
// dual-slope pwm timer. assumes a single core clock and an 8-bit register port.
package dsp_pkg;

   // register map, byte addresses on the 8-bit register port
   localparam logic [7:0] DSP_ADDR_CTRL_A   = 8'h24;
   localparam logic [7:0] DSP_ADDR_CTRL_B   = 8'h25;
   localparam logic [7:0] DSP_ADDR_COUNT    = 8'h26;
   localparam logic [7:0] DSP_ADDR_CMP_A    = 8'h27;
   localparam logic [7:0] DSP_ADDR_CMP_B    = 8'h28;
   localparam logic [7:0] DSP_ADDR_FLAGS    = 8'h29;

   // waveform_control_a fields
   localparam int         DSP_CA_ACT_A_HI   = 7;
   localparam int         DSP_CA_ACT_A_LO   = 6;
   localparam int         DSP_CA_ACT_B_HI   = 5;
   localparam int         DSP_CA_ACT_B_LO   = 4;
   localparam int         DSP_CA_MODE_HI    = 1;
   localparam int         DSP_CA_MODE_LO    = 0;
   localparam logic [7:0] DSP_CA_WR_MASK    = 8'hF3;
   localparam logic [7:0] DSP_CA_RESET      = 8'h00;

   // second control register fields
   localparam int         DSP_CB_FORCE_A    = 7;
   localparam int         DSP_CB_FORCE_B    = 6;
   localparam int         DSP_CB_MODE_BIT2  = 3;
   localparam int         DSP_CB_CS_HI      = 2;
   localparam int         DSP_CB_CS_LO      = 0;

   // flag register fields, write one to clear
   localparam int         DSP_FL_WRAP       = 0;
   localparam int         DSP_FL_MATCH_A    = 1;
   localparam int         DSP_FL_MATCH_B    = 2;

   // counter limits
   localparam logic [7:0] DSP_BOTTOM        = 8'h00;
   localparam logic [7:0] DSP_MAX           = 8'hFF;
   localparam logic [7:0] DSP_ONE           = 8'h01;

   // wave_mode_sel encodings
   localparam logic [2:0] DSP_MODE_PC_MAX   = 3'h1;
   localparam logic [2:0] DSP_MODE_CTC      = 3'h2;
   localparam logic [2:0] DSP_MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] DSP_MODE_PC_CMP   = 3'h5;
   localparam logic [2:0] DSP_MODE_FAST_CMP = 3'h7;

   // output action codes
   localparam logic [1:0] DSP_ACT_OFF       = 2'h0;
   localparam logic [1:0] DSP_ACT_TOGGLE    = 2'h1;
   localparam logic [1:0] DSP_ACT_CLEAR     = 2'h2;
   localparam logic [1:0] DSP_ACT_SET       = 2'h3;

   // prescaler: tick when the masked prescale bits are all ones
   localparam int         DSP_PRESC_W       = 10;
   localparam logic [9:0] DSP_DIV1_MASK     = 10'h000;
   localparam logic [9:0] DSP_DIV8_MASK     = 10'h007;
   localparam logic [9:0] DSP_DIV64_MASK    = 10'h03F;
   localparam logic [9:0] DSP_DIV256_MASK   = 10'h0FF;
   localparam logic [9:0] DSP_DIV1024_MASK  = 10'h3FF;
   localparam logic [9:0] DSP_PRESC_ONE     = 10'h001;

   typedef enum logic [1:0] {DSP_NORMAL, DSP_CTC, DSP_FAST, DSP_PHASE} dsp_mcls_t;
   typedef enum logic {DSP_UP, DSP_DOWN} dsp_dir_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dsp_bus_req_t;

   typedef struct packed {
      logic wave_out_a;
      logic wave_out_b;
      logic override_a;
      logic override_b;
   } dsp_pins_t;

endpackage

// *** dsp_timer.sv ***
// dsp_timer: eight-bit timer with normal, clear-on-match, single-slope and
// dual-slope pwm waveform generation on two channels, with register port.
// assumes bus strobes and the core clock share one domain; the port pin
// driver and its direction bit sit outside this block.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - modes 1 and 5 count up then down
// - top is 0xFF mode 1, compare A mode 5
// - dual-slope: clear on up match, set down
// - top held one tick, then counts down
// - dual-slope wrap flag set at bottom
// - code two non-inverted, three inverted pwm
// - code one toggles A only with bit2
// - nonzero action overrides pin; direction bit needed
// - dual-slope period is 510 ticks at 0xFF
// - compare bottom constant low in dual-slope, max constant high
// - symmetry transitions without a compare match
// - dual-slope compare at top: act at top
// - single-slope compare at top: act at bottom
// - non-pwm codes: off, toggle, clear, set
// - single-slope: match clears, bottom sets, or inverse
// - counter advances only on prescaled tick
// - control A at 0x24, fields, reset zero
// - action change applies at next match
// - counter eight bits, max 0xFF, bottom 0x00
// - reserved control bits read zero
module dsp_timer (
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire dsp_pkg::dsp_bus_req_t bus_req,
   output var  logic [7:0]          rdata,
   output var  dsp_pkg::dsp_pins_t  pins,
   output var  logic                wrap_flag,
   output var  logic                match_a_flag,
   output var  logic                match_b_flag
);

   typedef struct packed {
      logic [7:0]                        ctrl_a;
      logic                              wave_mode_bit2;
      logic [2:0]                        clk_sel;
      logic [dsp_pkg::DSP_PRESC_W-1:0]   presc;
      logic [7:0]                        count_value;
      dsp_pkg::dsp_dir_t                 dir;
      logic [7:0]                        cmp_a_buf;
      logic [7:0]                        cmp_b_buf;
      logic [7:0]                        cmp_a_act;
      logic [7:0]                        cmp_b_act;
      logic [1:0]                        act_a_eff;
      logic [1:0]                        act_b_eff;
      dsp_pkg::dsp_pins_t                pins;
      logic                              wrap_flag;
      logic                              match_a_flag;
      logic                              match_b_flag;
      logic [7:0]                        rdata;
   } dsp_state_t;

   dsp_state_t st_q;
   dsp_state_t st_d;

   // mode class from the three mode bits; reserved modes run as normal
   function automatic dsp_pkg::dsp_mcls_t dsp_mode_class(input logic [2:0] sel);
      dsp_pkg::dsp_mcls_t c;
      c = dsp_pkg::DSP_NORMAL;
      case (sel)
         dsp_pkg::DSP_MODE_PC_MAX,
         dsp_pkg::DSP_MODE_PC_CMP:   c = dsp_pkg::DSP_PHASE;
         dsp_pkg::DSP_MODE_CTC:      c = dsp_pkg::DSP_CTC;
         dsp_pkg::DSP_MODE_FAST_MAX,
         dsp_pkg::DSP_MODE_FAST_CMP: c = dsp_pkg::DSP_FAST;
         default:                    c = dsp_pkg::DSP_NORMAL;
      endcase
      return c;
   endfunction

   // next level of one waveform bit; tog_ok is false for channel B
   function automatic logic dsp_wave_next(
      input dsp_pkg::dsp_mcls_t m,
      input logic [1:0]         act,
      input logic               tog_ok,
      input logic               cur,
      input logic               hit,
      input logic               at_top,
      input logic               at_bot,
      input logic               cmp_top,
      input logic               up);
      logic v;
      v = cur;
      case (m)
         dsp_pkg::DSP_NORMAL,
         dsp_pkg::DSP_CTC: begin
            if (hit) begin
               case (act)
                  dsp_pkg::DSP_ACT_TOGGLE: v = ~cur;
                  dsp_pkg::DSP_ACT_CLEAR:  v = 1'b0;
                  dsp_pkg::DSP_ACT_SET:    v = 1'b1;
                  default:                 v = cur;
               endcase
            end
         end
         dsp_pkg::DSP_FAST: begin
            if (act[1]) begin
               if (at_top) begin
                  v = ~act[0];
               end else if (hit && !cmp_top) begin
                  v = act[0];
               end
            end else if (act == dsp_pkg::DSP_ACT_TOGGLE && tog_ok && hit) begin
               v = ~cur;
            end
         end
         dsp_pkg::DSP_PHASE: begin
            if (act[1]) begin
               if (at_top && cmp_top) begin
                  v = ~act[0];
               end else if (hit) begin
                  v = up ? act[0] : ~act[0];
               end else if (at_top) begin
                  // a missed upward match is made good at top
                  v = act[0];
               end else if (at_bot) begin
                  // level at bottom must match the start of an up slope
                  v = ~act[0];
               end
            end else if (act == dsp_pkg::DSP_ACT_TOGGLE && tog_ok && hit) begin
               v = ~cur;
            end
         end
         default: v = cur;
      endcase
      return v;
   endfunction

   dsp_pkg::dsp_mcls_t mcls;
   logic [2:0]         mode_sel;
   logic [7:0]         top;
   logic [9:0]         div_mask;
   logic               div_on;
   logic               tick;
   logic               at_top;
   logic               at_bot;
   logic               hit_a;
   logic               hit_b;
   logic               frc_a;
   logic               frc_b;
   logic               wrap_ev;
   logic               buf_load;
   logic [7:0]         cnt_nx;
   logic [1:0]         field_a;
   logic [1:0]         field_b;
   logic [1:0]         use_a;
   logic [1:0]         use_b;
   logic               wr_fl;
   logic [7:0]         clr;
   dsp_pkg::dsp_dir_t  dir_nx;

   assign mode_sel = {st_q.wave_mode_bit2,
                      st_q.ctrl_a[dsp_pkg::DSP_CA_MODE_HI:dsp_pkg::DSP_CA_MODE_LO]};
   assign mcls     = dsp_mode_class(mode_sel);
   assign field_a  = st_q.ctrl_a[dsp_pkg::DSP_CA_ACT_A_HI:dsp_pkg::DSP_CA_ACT_A_LO];
   assign field_b  = st_q.ctrl_a[dsp_pkg::DSP_CA_ACT_B_HI:dsp_pkg::DSP_CA_ACT_B_LO];

   // top comes from compare A in modes 2, 5 and 7, else fixed at max
   always_comb begin
      case (mode_sel)
         dsp_pkg::DSP_MODE_PC_CMP,
         dsp_pkg::DSP_MODE_FAST_CMP,
         dsp_pkg::DSP_MODE_CTC: top = st_q.cmp_a_act;
         default:               top = dsp_pkg::DSP_MAX;
      endcase
   end

   // prescaler; select values 0, 6 and 7 stop the timer
   always_comb begin
      div_on = 1'b1;
      case (st_q.clk_sel)
         3'h1:    div_mask = dsp_pkg::DSP_DIV1_MASK;
         3'h2:    div_mask = dsp_pkg::DSP_DIV8_MASK;
         3'h3:    div_mask = dsp_pkg::DSP_DIV64_MASK;
         3'h4:    div_mask = dsp_pkg::DSP_DIV256_MASK;
         3'h5:    div_mask = dsp_pkg::DSP_DIV1024_MASK;
         default: begin
            div_mask = dsp_pkg::DSP_DIV1_MASK;
            div_on   = 1'b0;
         end
      endcase
   end

   assign tick   = div_on && ((st_q.presc & div_mask) == div_mask);
   assign at_top = tick && (st_q.count_value == top) &&
                   (mcls == dsp_pkg::DSP_FAST ||
                    (mcls == dsp_pkg::DSP_PHASE && st_q.dir == dsp_pkg::DSP_UP));
   assign at_bot = tick && (mcls == dsp_pkg::DSP_PHASE) &&
                   (st_q.count_value == dsp_pkg::DSP_BOTTOM);
   assign hit_a  = tick && (st_q.count_value == st_q.cmp_a_act);
   assign hit_b  = tick && (st_q.count_value == st_q.cmp_b_act);

   // forced matches only in the non-pwm modes; no flag, no counter clear
   assign frc_a = bus_req.wr && bus_req.addr == dsp_pkg::DSP_ADDR_CTRL_B &&
                  bus_req.wdata[dsp_pkg::DSP_CB_FORCE_A] &&
                  (mcls == dsp_pkg::DSP_NORMAL || mcls == dsp_pkg::DSP_CTC);
   assign frc_b = bus_req.wr && bus_req.addr == dsp_pkg::DSP_ADDR_CTRL_B &&
                  bus_req.wdata[dsp_pkg::DSP_CB_FORCE_B] &&
                  (mcls == dsp_pkg::DSP_NORMAL || mcls == dsp_pkg::DSP_CTC);

   // a new action field is only picked up by a match
   assign use_a = (hit_a || frc_a) ? field_a : st_q.act_a_eff;
   assign use_b = (hit_b || frc_b) ? field_b : st_q.act_b_eff;

   // counter sequence per mode class
   always_comb begin
      cnt_nx   = st_q.count_value;
      wrap_ev  = 1'b0;
      buf_load = 1'b0;
      dir_nx   = st_q.dir;
      if (tick) begin
         case (mcls)
            dsp_pkg::DSP_NORMAL: begin
               cnt_nx  = st_q.count_value + dsp_pkg::DSP_ONE;
               wrap_ev = (st_q.count_value == dsp_pkg::DSP_MAX);
            end
            dsp_pkg::DSP_CTC: begin
               cnt_nx  = (st_q.count_value == top) ? dsp_pkg::DSP_BOTTOM :
                         st_q.count_value + dsp_pkg::DSP_ONE;
               wrap_ev = (st_q.count_value == dsp_pkg::DSP_MAX);
            end
            dsp_pkg::DSP_FAST: begin
               cnt_nx   = (st_q.count_value == top) ? dsp_pkg::DSP_BOTTOM :
                          st_q.count_value + dsp_pkg::DSP_ONE;
               wrap_ev  = (st_q.count_value == top);
               buf_load = (st_q.count_value == top);
            end
            dsp_pkg::DSP_PHASE: begin
               if (st_q.dir == dsp_pkg::DSP_UP) begin
                  if (st_q.count_value >= top) begin
                     // one tick at top, then turn round
                     cnt_nx   = (top == dsp_pkg::DSP_BOTTOM) ? dsp_pkg::DSP_BOTTOM :
                                st_q.count_value - dsp_pkg::DSP_ONE;
                     dir_nx   = dsp_pkg::DSP_DOWN;
                     buf_load = (st_q.count_value == top);
                  end else begin
                     cnt_nx = st_q.count_value + dsp_pkg::DSP_ONE;
                  end
               end else begin
                  if (st_q.count_value == dsp_pkg::DSP_BOTTOM) begin
                     cnt_nx   = (top == dsp_pkg::DSP_BOTTOM) ? dsp_pkg::DSP_BOTTOM :
                                dsp_pkg::DSP_ONE;
                     dir_nx   = dsp_pkg::DSP_UP;
                  end else begin
                     cnt_nx = st_q.count_value - dsp_pkg::DSP_ONE;
                  end
               end
               wrap_ev = (cnt_nx == dsp_pkg::DSP_BOTTOM) &&
                         (st_q.count_value != dsp_pkg::DSP_BOTTOM);
            end
            default: cnt_nx = st_q.count_value;
         endcase
      end
      if (mcls != dsp_pkg::DSP_PHASE) begin
         dir_nx = dsp_pkg::DSP_UP;
      end
   end

   assign wr_fl = bus_req.wr && bus_req.addr == dsp_pkg::DSP_ADDR_FLAGS;
   assign clr   = wr_fl ? bus_req.wdata : 8'h00;

   always_comb begin
      st_d.ctrl_a         = st_q.ctrl_a;
      st_d.wave_mode_bit2 = st_q.wave_mode_bit2;
      st_d.clk_sel        = st_q.clk_sel;
      st_d.presc          = st_q.presc + dsp_pkg::DSP_PRESC_ONE;
      st_d.count_value    = cnt_nx;
      st_d.dir            = dir_nx;
      st_d.cmp_a_buf      = st_q.cmp_a_buf;
      st_d.cmp_b_buf      = st_q.cmp_b_buf;
      st_d.rdata          = 8'h00;

      if (bus_req.wr) begin
         case (bus_req.addr)
            dsp_pkg::DSP_ADDR_CTRL_A:
               st_d.ctrl_a = bus_req.wdata & dsp_pkg::DSP_CA_WR_MASK;
            dsp_pkg::DSP_ADDR_CTRL_B: begin
               st_d.wave_mode_bit2 = bus_req.wdata[dsp_pkg::DSP_CB_MODE_BIT2];
               st_d.clk_sel = bus_req.wdata[dsp_pkg::DSP_CB_CS_HI:dsp_pkg::DSP_CB_CS_LO];
            end
            dsp_pkg::DSP_ADDR_COUNT: st_d.count_value = bus_req.wdata;
            dsp_pkg::DSP_ADDR_CMP_A: st_d.cmp_a_buf   = bus_req.wdata;
            dsp_pkg::DSP_ADDR_CMP_B: st_d.cmp_b_buf   = bus_req.wdata;
            default: st_d.rdata = 8'h00;
         endcase
      end

      if (bus_req.rd) begin
         case (bus_req.addr)
            dsp_pkg::DSP_ADDR_CTRL_A: st_d.rdata = st_q.ctrl_a;
            dsp_pkg::DSP_ADDR_CTRL_B:
               st_d.rdata = {4'h0, st_q.wave_mode_bit2, st_q.clk_sel};
            dsp_pkg::DSP_ADDR_COUNT:  st_d.rdata = st_q.count_value;
            dsp_pkg::DSP_ADDR_CMP_A:  st_d.rdata = st_q.cmp_a_buf;
            dsp_pkg::DSP_ADDR_CMP_B:  st_d.rdata = st_q.cmp_b_buf;
            dsp_pkg::DSP_ADDR_FLAGS:
               st_d.rdata = {5'h00, st_q.match_b_flag, st_q.match_a_flag, st_q.wrap_flag};
            default:                  st_d.rdata = 8'h00;
         endcase
      end

      // immediate modes follow the buffer; pwm modes load at the turn point
      if (mcls == dsp_pkg::DSP_NORMAL || mcls == dsp_pkg::DSP_CTC || buf_load) begin
         st_d.cmp_a_act = st_d.cmp_a_buf;
         st_d.cmp_b_act = st_d.cmp_b_buf;
      end else begin
         st_d.cmp_a_act = st_q.cmp_a_act;
         st_d.cmp_b_act = st_q.cmp_b_act;
      end

      st_d.act_a_eff = use_a;
      st_d.act_b_eff = use_b;

      st_d.pins.wave_out_a = dsp_wave_next(mcls, use_a, st_q.wave_mode_bit2,
                                           st_q.pins.wave_out_a, hit_a || frc_a,
                                           at_top, at_bot, st_q.cmp_a_act == top,
                                           st_q.dir == dsp_pkg::DSP_UP ||
                                           st_q.count_value == dsp_pkg::DSP_BOTTOM);
      st_d.pins.wave_out_b = dsp_wave_next(mcls, use_b, 1'b0,
                                           st_q.pins.wave_out_b, hit_b || frc_b,
                                           at_top, at_bot, st_q.cmp_b_act == top,
                                           st_q.dir == dsp_pkg::DSP_UP ||
                                           st_q.count_value == dsp_pkg::DSP_BOTTOM);

      // pin takeover follows the raw field, not the latched action
      st_d.pins.override_a = (field_a != dsp_pkg::DSP_ACT_OFF);
      st_d.pins.override_b = (field_b != dsp_pkg::DSP_ACT_OFF);

      // set beats a same-cycle clear
      st_d.wrap_flag    = wrap_ev ||
                          (st_q.wrap_flag && !clr[dsp_pkg::DSP_FL_WRAP]);
      st_d.match_a_flag = hit_a ||
                          (st_q.match_a_flag && !clr[dsp_pkg::DSP_FL_MATCH_A]);
      st_d.match_b_flag = hit_b ||
                          (st_q.match_b_flag && !clr[dsp_pkg::DSP_FL_MATCH_B]);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q        <= '0;
         st_q.ctrl_a <= dsp_pkg::DSP_CA_RESET;
         st_q.dir    <= dsp_pkg::DSP_UP;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata        = st_q.rdata;
   assign pins         = st_q.pins;
   assign wrap_flag    = st_q.wrap_flag;
   assign match_a_flag = st_q.match_a_flag;
   assign match_b_flag = st_q.match_b_flag;

endmodule
`default_nettype wire

// *** dsp_timer_checker.sv ***
// dsp_timer_checker: port-level assertions for the dual-slope pwm timer.
// assumes one core clock and the one-cycle register port of dsp_timer.
`timescale 1ns/1ps
`default_nettype none
module dsp_timer_checker (
   input wire logic                  core_clk,
   input wire logic                  rstn,
   input wire dsp_pkg::dsp_bus_req_t bus_req,
   input wire logic [7:0]            rdata,
   input wire dsp_pkg::dsp_pins_t    pins,
   input wire logic                  wrap_flag,
   input wire logic                  match_a_flag,
   input wire logic                  match_b_flag
);
   logic [2:0] cs_q;
   // shadow of clock select; zero means no tick at all
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cs_q <= 3'h0;
      end else if (bus_req.wr && bus_req.addr == 8'h25) begin
         cs_q <= bus_req.wdata[2:0];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_wr_ctrl;
      bus_req.wr && bus_req.addr == 8'h24;
   endsequence
   sequence s_rd_ctrl;
      bus_req.rd && bus_req.addr == 8'h24;
   endsequence
   property p_rdata_idle;
      !bus_req.rd |=> rdata == 8'h00;
   endproperty
   property p_resv_zero;
      s_rd_ctrl |=> rdata[3:2] == 2'h0;
   endproperty
   property p_readback;
      s_wr_ctrl ##1 s_rd_ctrl |=> rdata == ($past(bus_req.wdata, 2) & 8'hF3);
   endproperty
   property p_unmapped;
      bus_req.rd && (bus_req.addr < 8'h24 || bus_req.addr > 8'h29) |=> rdata == 8'h00;
   endproperty
   // takeover is decoded from the stored field, so it trails the write by two cycles
   property p_ovr_a;
      s_wr_ctrl |-> ##2 pins.override_a == ($past(bus_req.wdata[7:6], 2) != 2'h0);
   endproperty
   property p_ovr_b;
      s_wr_ctrl |-> ##2 pins.override_b == ($past(bus_req.wdata[5:4], 2) != 2'h0);
   endproperty
   property p_wrap_sticky;
      $fell(wrap_flag) |-> $past(bus_req.wr && bus_req.addr == 8'h29 && bus_req.wdata[0]);
   endproperty
   // force strobes act in the cycle of their own write; the guard still asks for two quiet cycles
   property p_stop_hold;
      cs_q == 3'h0 && !bus_req.wr && !$past(bus_req.wr) |=>
         $stable(pins.wave_out_a) && $stable(pins.wave_out_b) && $stable(match_a_flag);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero when idle");
   a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");
   a_readback: assert property (p_readback) else $error("control readback wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_ovr_a: assert property (p_ovr_a) else $error("override a wrong");
   a_ovr_b: assert property (p_ovr_b) else $error("override b wrong");
   a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap flag lost");
   a_stop_hold: assert property (p_stop_hold) else $error("change while stopped");
endmodule
bind dsp_timer dsp_timer_checker u_chk (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
   .rdata(rdata), .pins(pins), .wrap_flag(wrap_flag), .match_a_flag(match_a_flag),
   .match_b_flag(match_b_flag));
`default_nettype wire

// *** dsp_timer_test.sv ***
// dsp_timer_test: self-checking bench for dsp_timer.
// assumes the checker is bound and the pin load model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module dsp_timer_test;
   logic                  core_clk = 1'b0;
   logic                  rstn = 1'b0;
   dsp_pkg::dsp_bus_req_t bus_req = '0;
   logic [7:0]            rdata;
   dsp_pkg::dsp_pins_t    pins;
   logic                  wrap_flag, match_a_flag, match_b_flag;
   logic                  dir_out = 1'b0;
   logic                  port_val = 1'b1;
   logic                  pad_a, pad_b;
   logic                  rd_pend = 1'b0;
   logic [7:0]            exp_q[$];
   int                    fail_count = 0;
   int                    num_checks = 0;
   logic [7:0]            rv;
   logic [7:0]            acts = 8'h97;
   logic [3:0]            expw = 4'b0101;
   logic                  pw;
   int                    e;
   always #5 core_clk = ~core_clk;
   dsp_timer u_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .pins(pins), .wrap_flag(wrap_flag), .match_a_flag(match_a_flag),
      .match_b_flag(match_b_flag));
   dsp_pin_load u_load (.dir_out(dir_out), .port_val(port_val), .pins(pins), .pad_a(pad_a),
      .pad_b(pad_b));
   task automatic close_out;
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // cyc, wr and rd each rewrite the whole request, so strobes last one cycle
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         bus_req <= '0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(x);
   endtask
   always @(posedge core_clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) chk(1'b0, "read without note");
         else chk(rdata === exp_q.pop_front(), "read data");
      end
      rd_pend <= bus_req.rd;
   end
   task automatic wave_at(input logic ch, input logic lvl, output int c);
      c = 0;
      while ((ch ? pins.wave_out_b : pins.wave_out_a) !== lvl && c < 2000) begin
         cyc(1);
         #1;
         c++;
      end
      if (c >= 2000) begin
         chk(1'b0, "wave timeout");
         close_out();
      end
   endtask
   task automatic duty(input logic ch, input int hi, input int lo);
      int c;
      wave_at(ch, 1'b1, c);
      wave_at(ch, 1'b0, c);
      wave_at(ch, 1'b1, c);
      wave_at(ch, 1'b0, c);
      chk(c == hi, "high time");
      wave_at(ch, 1'b1, c);
      chk(c == lo, "low time");
   endtask
   task automatic edges(input int n, output int k);
      logic last;
      k = 0;
      last = pins.wave_out_a;
      repeat (n) begin
         cyc(1);
         #1;
         if (pins.wave_out_a !== last) k++;
         last = pins.wave_out_a;
      end
   endtask
   initial begin
      void'($urandom(32'h9AC4AF65));
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      rd(8'h24, 8'h00);
      rd(8'h30, 8'h00);
      repeat (4) begin
         rv = $urandom;
         wr(8'h24, rv);
         rd(8'h24, rv & 8'hF3);
         rv = $urandom;
         wr(8'h28, rv);
         rd(8'h28, rv);
      end
      pw = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(8'h24, {acts[2*i+:2], 6'h00});
         cyc(3);
         chk(pins.wave_out_a === pw, "early action");
         wr(8'h25, 8'h80);
         cyc(3);
         chk(pins.wave_out_a === expw[i], "forced action");
         pw = expw[i];
      end
      #1;
      chk(pad_a === 1'b1, "pad undriven");
      dir_out = 1'b1;
      #1;
      chk(pad_a === 1'b0, "pad driven");
      wr(8'h27, 8'h80);
      wr(8'h24, 8'h81);
      wr(8'h25, 8'h01);
      duty(1'b0, 256, 254);
      wr(8'h24, 8'hC1);
      duty(1'b0, 254, 256);
      wr(8'h25, 8'h00);
      rd(8'h29, 8'h07);
      chk((wrap_flag & match_a_flag & match_b_flag) === 1'b1, "flag pins set");
      wr(8'h29, 8'h07);
      rd(8'h29, 8'h00);
      cyc(1);
      #1;
      chk((wrap_flag | match_a_flag | match_b_flag) === 1'b0, "flag pins clear");
      // single-slope: set at top turn, clear at match 0x80
      wr(8'h27, 8'h80);
      wr(8'h24, 8'h83);
      wr(8'h25, 8'h01);
      duty(1'b0, 129, 127);
      // clear-on-match toggle: 0x41 ticks per level
      wr(8'h24, 8'h42);
      wr(8'h27, 8'h40);
      duty(1'b0, 65, 65);
      wr(8'h24, 8'h81);
      wr(8'h27, 8'hFF);
      wr(8'h25, 8'h01);
      cyc(600);
      edges(600, e);
      chk(e == 0 && pins.wave_out_a === 1'b1, "max level");
      wr(8'h27, 8'h00);
      cyc(600);
      edges(600, e);
      chk(e == 0 && pins.wave_out_a === 1'b0, "bottom level");
      wr(8'h27, 8'h80);
      wr(8'h24, 8'h41);
      edges(600, e);
      chk(e == 0, "toggle without bit2");
      wr(8'h27, 8'h40);
      wr(8'h25, 8'h09);
      cyc(300);
      edges(600, e);
      chk(e >= 4 && e <= 5, "toggle with bit2");
      wr(8'h28, 8'h10);
      wr(8'h24, 8'h21);
      duty(1'b1, 32, 96);
      rstn <= 1'b0;
      cyc(3);
      rstn <= 1'b1;
      rd(8'h24, 8'h00);
      cyc(3);
      close_out();
   end
endmodule
`default_nettype wire
